// *** sps_port.sv ***
/*
  Synchronous serial port, master or slave, with AXI4-Lite
  registers, halt/wait handling and one event request line.
  Assumes the far party keeps the link rules on its side.
*/
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
// Overview of operation
// - Full-duplex three-line exchange, master or slave
// - Simplex two-line option
// - Six master clock rates, fastest clk/4
// - External master clock at most clk/2
// - Drive clock as master, take it as slave
// - Select line picks one slave at once
// - Select from pin or software level bit
// - Programmable clock polarity and phase
// - Done, collision, mode fault, overrun flags
// - Shared request gated by enable and mask
// - Runs in wait; events end wait
// - Halt freezes registers, port inactive
// - Slave done wakes from halt; data kept
// - Second done before clear sets overrun
// - Halt wake only if selected at entry
// - Master holds pin select low over halt
// - Extra frame after wake restores normal state
// - Leaving slave mode restores normal state
`timescale 1ns/1ps
module sps_port
  import sps_pkg::*;
(
  input  logic        clk,
  input  logic        rst,
  input  logic [3:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  input  logic [3:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  input  logic        cpuIrqMask,
  input  logic        haltMode,
  output logic        irq,
  output logic        waitWake,
  output logic        haltWake,
  sps_link_if.dev     link
);
  logic [CTL_W-1:0] ctrl;
  logic        en, mstr, cpol, cpha, ie, ssm, soft_select_level, simplex;
  logic [3:0]  pinMeta, pinSync;
  logic        ssS, sckS, mosiS, misoS, sckPrev;
  logic        awFull, wFull, doWr;
  logic [3:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wrCtrl, wrStat, wrData, rdData, rdTake;
  logic        doneF, wcol, mode_fault_flag, overrun_flag;
  logic [7:0]  rxData;
  logic        busyM, sckInt, tick, busy, startM, modeFault;
  logic [7:0]  halfCnt;
  logic [4:0]  edgeCnt;
  logic        slaveMode, selected, slvRun, sEdge;
  logic        lead, trail, txBit, engDone, engActive, lostByte;
  logic [7:0]  engRx;
  logic        haltPrev, haltArm, haltState;

  function automatic logic is_mapped(input logic [3:0] a);
    return (a == OFF_CTRL) || (a == OFF_STAT) || (a == OFF_DATA);
  endfunction

  assign en      = ctrl[CTL_EN];
  assign mstr    = ctrl[CTL_MSTR];
  assign cpol    = ctrl[CTL_CPOL];
  assign cpha    = ctrl[CTL_CPHA];
  assign ie      = ctrl[CTL_IE];
  assign ssm     = ctrl[CTL_SSM];
  assign soft_select_level     = ctrl[CTL_SSI];
  assign simplex = ctrl[CTL_SIMPLEX];

  // ***********************************
  // Pin resynchronisers {ssN, sck, mosi, miso}
  // ***********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= 4'h8;
      pinSync <= 4'h8;
      sckPrev <= 1'b0;
    end else begin
      pinMeta <= {link.ssN, link.sck, link.mosi, link.miso};
      pinSync <= pinMeta;
      sckPrev <= pinSync[2];
    end
  end
  assign {ssS, sckS, mosiS, misoS} = pinSync;

  // ***********************************
  // AXI4-Lite slave
  // ***********************************
  assign awready = !awFull && !bvalid;
  assign wready  = !wFull && !bvalid;
  assign arready = !rvalid;
  assign doWr    = awFull && wFull && !bvalid;
  assign rdTake  = arvalid && arready;
  // Registers are frozen while halted
  assign wrCtrl = doWr && awAddr == OFF_CTRL && !haltMode;
  assign wrStat = doWr && awAddr == OFF_STAT && wStrb[0] && !haltMode;
  assign wrData = doWr && awAddr == OFF_DATA && wStrb[0] && !haltMode;
  assign rdData = rdTake && araddr == OFF_DATA;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awFull <= 1'b0;
      wFull  <= 1'b0;
      awAddr <= 4'h0;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWr) begin
      awFull <= 1'b0;
      wFull  <= 1'b0;
      bvalid <= 1'b1;
      bresp  <= is_mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (awvalid && awready) begin
        awFull <= 1'b1;
        awAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wFull <= 1'b1;
        wData <= wdata;
        wStrb <= wstrb;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (rdTake) begin
      rvalid <= 1'b1;
      rresp  <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (araddr == OFF_CTRL)
        rdata <= {21'h000000, ctrl};
      else if (araddr == OFF_STAT)
        rdata <= {26'h0000000, haltState, busy, overrun_flag, mode_fault_flag, wcol, doneF};
      else if (araddr == OFF_DATA)
        rdata <= {24'h000000, rxData};
      else
        rdata <= 32'h0000_0000;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ***********************************
  // Control register
  // ***********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RST;
    end else if (modeFault) begin
      // Fault drops master and enable so two masters stop fighting
      ctrl[CTL_MSTR] <= 1'b0;
      ctrl[CTL_EN]   <= 1'b0;
    end else if (wrCtrl) begin
      if (wStrb[0])
        ctrl[7:0] <= wData[7:0];
      if (wStrb[1])
        ctrl[CTL_W-1:8] <= wData[CTL_W-1:8];
    end
  end

  // ***********************************
  // Master clock generator
  // ***********************************
  assign busy      = busyM || engActive;
  assign startM    = wrData && en && mstr && !busy;
  assign modeFault = en && mstr && !ssm && !ssS;
  assign tick = busyM && !haltMode
             && halfCnt == sps_half_lim(ctrl[CTL_RATE +: 3]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyM   <= 1'b0;
      sckInt  <= 1'b0;
      halfCnt <= 8'h00;
      edgeCnt <= 5'h00;
    end else if (modeFault || !en || !mstr) begin
      busyM   <= 1'b0;
      sckInt  <= 1'b0;
      halfCnt <= 8'h00;
    end else if (startM) begin
      busyM   <= 1'b1;
      halfCnt <= 8'h00;
      edgeCnt <= 5'h00;
    end else if (tick) begin
      halfCnt <= 8'h00;
      sckInt  <= ~sckInt;
      edgeCnt <= edgeCnt + 5'h01;
      if (edgeCnt == EDGE_LAST)
        busyM <= 1'b0;
    end else if (busyM && !haltMode) begin
      halfCnt <= halfCnt + 8'h01;
    end
  end

  // ***********************************
  // Slave edges and select
  // ***********************************
  assign slaveMode = en && !mstr;
  assign selected  = ssm ? !soft_select_level : !ssS;
  // Halted slave keeps shifting only if armed at halt entry
  assign slvRun = slaveMode && selected
               && (!haltMode || haltArm);
  assign sEdge = slvRun && sckS != sckPrev;
  // Lead is the edge leaving the idle level
  assign lead  = mstr ? (tick && !edgeCnt[0]) : (sEdge && sckS != cpol);
  assign trail = mstr ? (tick && edgeCnt[0]) : (sEdge && sckS == cpol);

  sps_shifter u_eng (
    .clk       (clk),
    .rst       (rst),
    .load      (wrData && !busy),
    .loadByte  (wData[7:0]),
    .abort     ((slaveMode && !selected) || !en),
    .cpha      (cpha),
    .lead      (lead),
    .trail     (trail),
    .rxBit     (mstr ? misoS : mosiS),
    .txBit     (txBit),
    .rxByte    (engRx),
    .active    (engActive),
    .frameDone (engDone)
  );

  // ***********************************
  // Status flags, set wins over clear
  // ***********************************
  assign lostByte = engDone && doneF && !rdData;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doneF  <= 1'b0;
      wcol   <= 1'b0;
      mode_fault_flag   <= 1'b0;
      overrun_flag    <= 1'b0;
      rxData <= 8'h00;
    end else begin
      if (engDone)
        doneF <= 1'b1;
      else if (rdData)
        doneF <= 1'b0;
      // Received byte held for reading after a wake
      if (engDone && !lostByte)
        rxData <= engRx;
      if (wrData && busy)
        wcol <= 1'b1;
      else if (wrStat && wData[ST_WCOL])
        wcol <= 1'b0;
      if (modeFault)
        mode_fault_flag <= 1'b1;
      else if (wrStat && wData[ST_MODE_FAULT_FLAG])
        mode_fault_flag <= 1'b0;
      if (lostByte)
        overrun_flag <= 1'b1;
      else if (wrStat && wData[ST_OVR])
        overrun_flag <= 1'b0;
    end
  end

  // ***********************************
  // Halt tracking
  // ***********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      haltPrev  <= 1'b0;
      haltArm   <= 1'b0;
      haltState <= 1'b0;
    end else begin
      haltPrev <= haltMode;
      if (haltMode && !haltPrev) begin
        haltArm   <= slaveMode && selected;
        haltState <= slaveMode;
      end else begin
        if (!haltMode)
          haltArm <= 1'b0;
        if (!slaveMode)
          haltState <= 1'b0;
        else if (engDone && !haltMode)
          haltState <= 1'b0;
      end
    end
  end

  // ***********************************
  // Event request and wake lines
  // ***********************************
  assign irq = ie && !cpuIrqMask && (doneF || mode_fault_flag || overrun_flag);
  assign waitWake = ie && (doneF || mode_fault_flag || overrun_flag);
  // Only the done event ends halt
  assign haltWake = haltMode && haltArm && ie && doneF;

  // ***********************************
  // Pin drivers
  // ***********************************
  assign link.devSckO   = cpol ^ sckInt;
  assign link.devSckOe  = en && mstr;
  assign link.devMosiO  = txBit;
  assign link.devMosiOe = en && mstr;
  assign link.devMisoO  = txBit;
  // Simplex slave stays off the return line; selected only
  assign link.devMisoOe = slaveMode && selected && !simplex;
endmodule // sps_port

// *** sps_pkg.sv ***
/*
  Shared constants for the serial port pair: register map, field
  positions, reset values and clock-rate arithmetic.
  Assumes both ends and the bit engine import it whole.
*/
package sps_pkg;

  // ***********************************
  // Register map (byte addresses)
  // ***********************************
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;

  // ***********************************
  // Control fields
  // ***********************************
  localparam int CTL_W       = 11;
  localparam int CTL_EN      = 0;
  localparam int CTL_MSTR    = 1;
  localparam int CTL_CPOL    = 2;
  localparam int CTL_CPHA    = 3;
  localparam int CTL_RATE    = 4;
  localparam int CTL_IE      = 7;
  localparam int CTL_SSM     = 8;
  localparam int CTL_SSI     = 9;
  localparam int CTL_SIMPLEX = 10;
  localparam logic [CTL_W-1:0] CTRL_RST = 11'h000;

  // ***********************************
  // Status fields
  // ***********************************
  localparam int ST_DONE  = 0;
  localparam int ST_WCOL  = 1;
  localparam int ST_MODE_FAULT_FLAG  = 2;
  localparam int ST_OVR   = 3;
  localparam int ST_BUSY  = 4;
  localparam int ST_HALTS = 5;

  // ***********************************
  // Counts and bus answers
  // ***********************************
  localparam logic [2:0] RATE_MAX   = 3'h5;
  localparam logic [7:0] HALF_BASE  = 8'h02;
  localparam logic [4:0] EDGE_LAST  = 5'h0F;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [7:0] PTN_HALF   = 8'h08;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Half period in cycles minus one; six rates, clk/4 .. clk/128
  function automatic logic [7:0] sps_half_lim(input logic [2:0] rate);
    logic [2:0] r;
    r = (rate > RATE_MAX) ? RATE_MAX : rate;
    return (HALF_BASE << r) - 8'h01;
  endfunction

endpackage

// *** sps_link_if.sv ***
/*
  Four-wire serial link between the port and its far party.
  Assumes each end drives only its own out/enable pairs.
*/
`timescale 1ns/1ps
interface sps_link_if;
  logic devSckO, devSckOe, devMosiO, devMosiOe, devMisoO, devMisoOe;
  logic ptnSckO, ptnSckOe, ptnMosiO, ptnMosiOe, ptnMisoO, ptnMisoOe;
  logic ptnSsNO;
  logic sck, mosi, miso, ssN;

  // Undriven lines settle low, select always follows the partner's ptnSsNO
  assign sck  = devSckOe  ? devSckO  : (ptnSckOe  ? ptnSckO  : 1'b0);
  assign mosi = devMosiOe ? devMosiO : (ptnMosiOe ? ptnMosiO : 1'b0);
  assign miso = devMisoOe ? devMisoO : (ptnMisoOe ? ptnMisoO : 1'b0);
  assign ssN  = ptnSsNO;

  modport dev (output devSckO, devSckOe, devMosiO, devMosiOe,
               output devMisoO, devMisoOe,
               input sck, mosi, miso, ssN);
  modport ptn (output ptnSckO, ptnSckOe, ptnMosiO, ptnMosiOe,
               output ptnMisoO, ptnMisoOe, ptnSsNO,
               input sck, mosi, miso);
endinterface

// *** sps_shifter.sv ***
/*
  Eight-bit shift engine, MSB first, sampling and shifting on the
  edges chosen by the phase bit.
  Assumes lead/trail are one-cycle pulses on the clk domain.
*/
`timescale 1ns/1ps
module sps_shifter
  import sps_pkg::*;
(
  input  logic       clk,
  input  logic       rst,
  input  logic       load,
  input  logic [7:0] loadByte,
  input  logic       abort,
  input  logic       cpha,
  input  logic       lead,
  input  logic       trail,
  input  logic       rxBit,
  output logic       txBit,
  output logic [7:0] rxByte,
  output logic       active,
  output logic       frameDone
);
  logic [7:0] tx;
  logic [2:0] cnt;
  logic       first;
  logic       sampleEdge;
  logic       shiftEdge;

  assign sampleEdge = cpha ? trail : lead;
  assign shiftEdge  = cpha ? lead : trail;
  assign txBit  = tx[7];
  assign active = !first;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx        <= 8'h00;
      rxByte    <= 8'h00;
      cnt       <= 3'h0;
      first     <= 1'b1;
      frameDone <= 1'b0;
    end else begin
      frameDone <= 1'b0;
      if (load) begin
        tx    <= loadByte;
        cnt   <= 3'h0;
        first <= 1'b1;
      end else if (abort) begin
        cnt   <= 3'h0;
        first <= 1'b1;
      end else begin
        // Phase 1 holds the MSB through the first edge
        if (shiftEdge && !(cpha && first))
          tx <= {tx[6:0], 1'b0};
        if (lead)
          first <= 1'b0;
        if (sampleEdge) begin
          rxByte <= {rxByte[6:0], rxBit};
          cnt    <= cnt + 3'h1;
          if (cnt == BIT_LAST) begin
            frameDone <= 1'b1;
            first     <= 1'b1;
          end
        end
      end
    end
  end
endmodule // sps_shifter

// *** sps_partner.sv ***
/*
  Far party of the link: a plain master or slave driven by user
  strobes. Assumes the same clk as the port; pins are resynchronised.
*/
`timescale 1ns/1ps
module sps_partner
  import sps_pkg::*;
(
  input  logic       clk,
  input  logic       rst,
  input  logic       asMaster,
  input  logic       cpol,
  input  logic       cpha,
  input  logic       selHold,
  input  logic       start,
  input  logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic       done,
  output logic       busy,
  sps_link_if.ptn    link
);
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  logic       sckPrev;
  logic       busyM;
  logic       sckInt;
  logic [7:0] halfCnt;
  logic [4:0] edgeCnt;
  logic       tick;
  logic       lead;
  logic       trail;
  logic       sEdge;
  logic       txBit;
  logic       engDone;
  logic       engActive;
  logic [7:0] engRx;

  // ***********************************
  // Pin resynchronisers {sck, mosi, miso}
  // ***********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
      sckPrev <= 1'b0;
    end else begin
      pinMeta <= {link.sck, link.mosi, link.miso};
      pinSync <= pinMeta;
      sckPrev <= pinSync[2];
    end
  end

  // ***********************************
  // Clock generation when acting as master
  // ***********************************
  assign tick = busyM && (halfCnt == PTN_HALF - 8'h01);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyM   <= 1'b0;
      sckInt  <= 1'b0;
      halfCnt <= 8'h00;
      edgeCnt <= 5'h00;
    end else if (!asMaster) begin
      busyM   <= 1'b0;
      sckInt  <= 1'b0;
    end else if (start && !busyM) begin
      busyM   <= 1'b1;
      halfCnt <= 8'h00;
      edgeCnt <= 5'h00;
    end else if (tick) begin
      halfCnt <= 8'h00;
      sckInt  <= ~sckInt;
      edgeCnt <= edgeCnt + 5'h01;
      if (edgeCnt == EDGE_LAST)
        busyM <= 1'b0;
    end else if (busyM) begin
      halfCnt <= halfCnt + 8'h01;
    end
  end

  // Slow master clock keeps the port within half its clock
  assign sEdge = pinSync[2] != sckPrev;
  assign lead  = asMaster ? (tick && !edgeCnt[0])
                          : (sEdge && pinSync[2] != cpol);
  assign trail = asMaster ? (tick && edgeCnt[0])
                          : (sEdge && pinSync[2] == cpol);

  sps_shifter u_eng (
    .clk       (clk),
    .rst       (rst),
    .load      (start && !busy),
    .loadByte  (txByte),
    .abort     (1'b0),
    .cpha      (cpha),
    .lead      (lead),
    .trail     (trail),
    .rxBit     (asMaster ? pinSync[0] : pinSync[1]),
    .txBit     (txBit),
    .rxByte    (engRx),
    .active    (engActive),
    .frameDone (engDone)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxByte <= 8'h00;
      done   <= 1'b0;
    end else begin
      done <= engDone;
      if (engDone)
        rxByte <= engRx;
    end
  end

  assign busy = busyM || engActive;

  // Select one slave per frame; selHold parks it low for halt
  assign link.ptnSsNO   = !((asMaster && busyM) || selHold);
  assign link.ptnSckO   = cpol ^ sckInt;
  assign link.ptnSckOe  = asMaster;
  assign link.ptnMosiO  = txBit;
  assign link.ptnMosiOe = asMaster;
  assign link.ptnMisoO  = txBit;
  assign link.ptnMisoOe = !asMaster;
endmodule // sps_partner

// *** sps_link_props.sv ***
/*
  Concurrent checks on the serial link between port and partner.
  Assumes one clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module sps_link_props (
  input logic clk,
  input logic rst,
  input logic devSckOe,
  input logic devMosiOe,
  input logic devMisoOe,
  input logic ptnSckOe,
  input logic ptnMisoOe,
  input logic sck,
  input logic ssN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ***********************************
  // Link rules
  // ***********************************
  // Fastest rate is clk/4: two cycles per level
  a_sck_half_min: assert property (devSckOe && $past(devSckOe) &&
    $changed(sck) |=> $stable(sck)) else $error("sck level too short");
  // Mode fault must end a clock fight within a few cycles
  a_sck_contention: assert property (
    not ((devSckOe && ptnSckOe) [*6])) else $error("sck driven twice");
  a_miso_single: assert property (!(devMisoOe && ptnMisoOe))
    else $error("miso driven twice");
  a_miso_deselect: assert property (ssN [*4] |-> !devMisoOe)
    else $error("miso driven while deselected");
  a_master_no_miso: assert property (devSckOe |-> !devMisoOe)
    else $error("master drives miso");
  a_slave_ext_clk: assert property (devMisoOe |->
    ptnSckOe && !devSckOe) else $error("slave without outside clock");
  a_slave_no_mosi: assert property (devMisoOe |-> !devMosiOe)
    else $error("slave drives mosi");
  a_master_mosi: assert property (devSckOe |-> devMosiOe)
    else $error("master leaves mosi undriven");

  cover property ($rose(devSckOe));
  cover property ($rose(devMisoOe));
  cover property (ptnSckOe && !ssN && $changed(sck));
endmodule // sps_link_props

// *** spi_master_slave_port_tb_top.sv ***
/*
  Bench for the port and partner joined by one link.
  Assumes AXI4-Lite answers within the watchdog span.
*/
`timescale 1ns/1ps
module spi_master_slave_port_tb_top;
  import sps_pkg::*;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cpuIrqMask, haltMode;
  logic irq, waitWake, haltWake, pMaster, pCpol, pCpha, pHold;
  logic pStart, pDone, pBusy, misoOn;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, lastResp;
  logic [7:0] pTx, pRx, b;
  int failures, checks;

  sps_link_if link ();
  sps_port i_sps_port (.clk(clk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cpuIrqMask(cpuIrqMask), .haltMode(haltMode),
    .irq(irq), .waitWake(waitWake), .haltWake(haltWake), .link(link));
  sps_partner i_sps_partner (.clk(clk), .rst(rst), .asMaster(pMaster),
    .cpol(pCpol), .cpha(pCpha), .selHold(pHold), .start(pStart),
    .txByte(pTx), .rxByte(pRx), .done(pDone), .busy(pBusy), .link(link));
  sps_link_props i_sps_link_props (.clk(clk), .rst(rst),
    .devSckOe(link.devSckOe), .devMosiOe(link.devMosiOe),
    .devMisoOe(link.devMisoOe), .ptnSckOe(link.ptnSckOe),
    .ptnMisoOe(link.ptnMisoOe), .sck(link.sck), .ssN(link.ssN));

  // ***********************************
  // Clock, monitors, helpers
  // ***********************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (link.devMisoOe === 1'b1) misoOn = 1'b1;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is sampled at the falling edge, acted on at the rising one
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // Own flag: the raised valids are not visible until this step ends
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      if (tb) lastResp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    // Idle edge so a following call never re-raises in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ta, tb;
    tb = 1'b0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = arvalid && arready;
      tb = rready && rvalid;
      if (tb) begin
        d = rdata;
        lastResp = rresp;
      end
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
    end
    @(posedge clk);
  endtask

  task automatic pload(input logic [7:0] x);
    pTx <= x; pStart <= 1'b1;
    @(posedge clk);
    pStart <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pframe(input logic [7:0] x);
    pload(x);
    do @(negedge clk); while (pDone !== 1'b1);
    // Partner stays busy to its last edge and ignores starts till then
    do @(negedge clk); while (pBusy !== 1'b0);
    @(posedge clk);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    results();
  end

  // ***********************************
  // Tests
  // ***********************************
  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 4'h0; araddr = 4'h0;
    wdata = 32'h0; wstrb = 4'h0; cpuIrqMask = 1'b0; haltMode = 1'b0;
    pMaster = 1'b0; pCpol = 1'b0; pCpha = 1'b0; pHold = 1'b0;
    pStart = 1'b0; pTx = 8'h00; misoOn = 1'b0;
    failures = 0; checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFF_CTRL, v); chk("ctrl reset", v, 32'h0);
    rd(OFF_STAT, v); chk("stat reset", v, 32'h0);
    rd(4'hC, v); chk("unmapped data", v, 32'h0);
    chk("unmapped resp", {30'h0, lastResp}, {30'h0, RESP_SLVERR});
    // Device master, all four clock modes, rate clk/16
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 32'h3A3 | {28'h0, m[0], m[1], 2'h0});
      pCpol <= m[1]; pCpha <= m[0];
      b = 8'hC3 - 8'(m);
      pload(8'h5A ^ b);
      wr(OFF_DATA, {24'h0, b});
      wr(OFF_DATA, 32'h0);
      // With phase 0 done comes before the last clock edge; wait for busy to end too
      do rd(OFF_STAT, v); while (v[0] !== 1'b1 || v[4] !== 1'b0);
      chk("stat done wcol", v, 32'h3);
      chk("irq", {31'h0, irq}, 32'h1);
      cpuIrqMask <= 1'b1;
      @(negedge clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      chk("wait wake", {31'h0, waitWake}, 32'h1);
      @(posedge clk);
      cpuIrqMask <= 1'b0;
      rd(OFF_DATA, v); chk("master rx", v, {24'h0, 8'h5A ^ b});
      chk("slave rx", {24'h0, pRx}, {24'h0, b});
      wr(OFF_STAT, 32'h2);
      rd(OFF_STAT, v); chk("stat clear", v, 32'h0);
    end
    // Mode fault: pin select pulled low under a master
    pMaster <= 1'b1; pHold <= 1'b1; pCpol <= 1'b0; pCpha <= 1'b0;
    wr(OFF_CTRL, 32'h3);
    rd(OFF_STAT, v); chk("mode_fault_flag", v & 32'h4, 32'h4);
    rd(OFF_CTRL, v); chk("mode_fault_flag ctrl", v, 32'h0);
    wr(OFF_STAT, 32'h4);
    pHold <= 1'b0;
    // Slave on pin select; second frame before read overruns
    wr(OFF_CTRL, 32'h81);
    wr(OFF_DATA, 32'h6C);
    pframe(8'h81);
    chk("slave reply", {24'h0, pRx}, 32'h6C);
    pframe(8'h7E);
    rd(OFF_STAT, v); chk("ovr", v, 32'h9);
    rd(OFF_DATA, v); chk("ovr keeps", v, 32'h81);
    wr(OFF_STAT, 32'h8);
    rd(OFF_STAT, v); chk("done cleared", v, 32'h0);
    // Simplex receive: miso never driven
    wr(OFF_CTRL, 32'h401);
    misoOn = 1'b0;
    pframe(8'hB4);
    chk("simplex oe", {31'h0, misoOn}, 32'h0);
    rd(OFF_DATA, v); chk("simplex rx", v, 32'hB4);
    // Halt entered while deselected: no wake
    wr(OFF_CTRL, 32'h81);
    haltMode <= 1'b1;
    pframe(8'h42);
    chk("no wake", {31'h0, haltWake}, 32'h0);
    rd(OFF_STAT, v); chk("halt state", v, 32'h20);
    haltMode <= 1'b0;
    // Halt entered while selected: done wakes, data kept
    pHold <= 1'b1;
    repeat (4) @(posedge clk);
    haltMode <= 1'b1;
    wr(OFF_CTRL, 32'h0);
    pframe(8'h99);
    chk("halt wake", {31'h0, haltWake}, 32'h1);
    rd(OFF_CTRL, v); chk("ctrl frozen", v, 32'h81);
    haltMode <= 1'b0;
    pHold <= 1'b0;
    rd(OFF_DATA, v); chk("wake rx", v, 32'h99);
    pframe(8'h24);
    rd(OFF_STAT, v); chk("normal again", v, 32'h1);
    rd(OFF_DATA, v); chk("extra rx", v, 32'h24);
    results();
  end
endmodule // spi_master_slave_port_tb_top
